// ===== inc/itt_pipe_if.sv
/*
 * Carrier between the register bank and the sample marker pipeline.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/100ps

interface itt_pipe_if #(
    parameter int SAMPLE_W = 12
);
    logic [SAMPLE_W-1:0] sample_in;
    logic marker_in;
    logic marker_en;
    logic [SAMPLE_W-1:0] sample_out;

    modport src (
        output sample_in,
        output marker_in,
        output marker_en,
        input sample_out
    );

    modport pipe (
        input sample_in,
        input marker_in,
        input marker_en,
        output sample_out
    );
endinterface

// ===== inc/itt_pkg.sv
/*
 * Constants for the interleave trim and sample marker register bank.
 * Assumes an 8-bit register port with 12-bit byte addresses.
 */
package itt_pkg;

    // ------------------------------------------------------------
    // Register port geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    localparam int TRIM_W = 8;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [11:0] OFF_BANK0_DUAL = 12'h102;
    localparam logic [11:0] OFF_BANK0_SINGLE = 12'h103;
    localparam logic [11:0] OFF_BANK1_DUAL = 12'h112;
    localparam logic [11:0] OFF_BANK1_SINGLE = 12'h113;
    localparam logic [11:0] OFF_BANK4 = 12'h142;
    localparam logic [11:0] OFF_BANK5 = 12'h152;
    localparam logic [11:0] OFF_MARKER_CTRL = 12'h160;

    // ------------------------------------------------------------
    // Field layout and reset values
    // ------------------------------------------------------------
    localparam int MARKER_EN_BIT = 0;
    localparam logic [7:0] MARKER_CTRL_RESET = 8'h00;
    localparam logic [7:0] READ_IDLE = 8'h00;

    // ------------------------------------------------------------
    // Datapath defaults
    // ------------------------------------------------------------
    localparam int SAMPLE_W_DEF = 12;
    localparam int LATENCY_DEF = 4;

endpackage

// ===== rtl/itt_marker_pipe.sv
/*
 * Delay line carrying samples and the timestamp marker side by side.
 * Assumes one sample per clock and a synchronous active-low reset.
 */
`timescale 1ns/100ps

module itt_marker_pipe #(
    parameter int SAMPLE_W = 12,
    parameter int LATENCY = 4
) (
    input wire logic core_clk,
    input wire logic resetn,
    itt_pipe_if.pipe pif
);

    initial begin
        if (SAMPLE_W < 2 || LATENCY < 1) begin
            $error("itt_marker_pipe: SAMPLE_W >= 2 and LATENCY >= 1");
        end
    end

    logic [SAMPLE_W-1:0] stage_sample [LATENCY];
    logic stage_marker [LATENCY];
    logic [SAMPLE_W-1:0] last_sample;
    logic last_marker;
    logic [SAMPLE_W-1:0] next_sample_out;

    assign last_sample = stage_sample[LATENCY-1];
    assign last_marker = stage_marker[LATENCY-1];

    // ------------------------------------------------------------
    // Marker rides the same stages as the sample, so they cannot skew
    // ------------------------------------------------------------
    assign next_sample_out = pif.marker_en
        ? {last_sample[SAMPLE_W-1:1], last_marker}
        : last_sample;

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            for (int i = 0; i < LATENCY; i++) begin
                stage_sample[i] <= '0;
                stage_marker[i] <= 1'b0;
            end
            pif.sample_out <= '0;
        end else begin
            stage_sample[0] <= pif.sample_in;
            stage_marker[0] <= pif.marker_in;
            for (int i = 1; i < LATENCY; i++) begin
                stage_sample[i] <= stage_sample[i-1];
                stage_marker[i] <= stage_marker[i-1];
            end
            pif.sample_out <= next_sample_out;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic [7:0] fill;

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            fill <= 8'h00;
        end else if (fill < 8'(LATENCY + 1)) begin
            fill <= fill + 8'h01;
        end
    end

    marker_align_a: assert property (
        @(posedge core_clk) disable iff (!resetn)
        fill == 8'(LATENCY + 1) |->
        pif.sample_out[0] == ($past(pif.marker_en)
            ? $past(pif.marker_in, LATENCY + 1)
            : $past(pif.sample_in[0], LATENCY + 1)))
        else $error("marker bit not aligned with its sample");

    sample_upper_a: assert property (
        @(posedge core_clk) disable iff (!resetn)
        fill == 8'(LATENCY + 1) |->
        pif.sample_out[SAMPLE_W-1:1] == $past(pif.sample_in[SAMPLE_W-1:1], LATENCY + 1))
        else $error("sample latency wrong");

endmodule

// ===== rtl/itt_regs.sv
/*
 * Interleave timing trim and sample marker register bank.
 * Assumes a plain register port on core_clk, fuse values that are
 * stable while resetn is low, and one converter sample per clock.
 */
//
// Contract
// - Dual mode: bank 0 takes dual trim
// - Single mode: bank 0 takes single trim
// - Dual mode: bank 1 takes dual trim
// - Single mode: bank 1 takes single trim
// - Bank 4 trim applies in both modes
// - Bank 5 trim applies in both modes
// - Trims load fuse values, stay read/write
// - Control bit 0 puts marker on LSB
// - Marker latency equals sample latency
`timescale 1ns/100ps

module itt_regs #(
    parameter int SAMPLE_W = itt_pkg::SAMPLE_W_DEF,
    parameter int LATENCY = itt_pkg::LATENCY_DEF
) (
    input wire logic core_clk,
    input wire logic resetn,

    input wire logic [itt_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [itt_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [itt_pkg::DATA_W-1:0] reg_rdata,

    input wire logic single_channel_mode,

    input wire logic [itt_pkg::TRIM_W-1:0] fuse_bank0_dual,
    input wire logic [itt_pkg::TRIM_W-1:0] fuse_bank0_single,
    input wire logic [itt_pkg::TRIM_W-1:0] fuse_bank1_dual,
    input wire logic [itt_pkg::TRIM_W-1:0] fuse_bank1_single,
    input wire logic [itt_pkg::TRIM_W-1:0] fuse_bank4,
    input wire logic [itt_pkg::TRIM_W-1:0] fuse_bank5,

    output logic [itt_pkg::TRIM_W-1:0] bank0_timing,
    output logic [itt_pkg::TRIM_W-1:0] bank1_timing,
    output logic [itt_pkg::TRIM_W-1:0] bank4_timing,
    output logic [itt_pkg::TRIM_W-1:0] bank5_timing,

    input wire logic [SAMPLE_W-1:0] adc_sample,
    input wire logic marker_in,
    output logic [SAMPLE_W-1:0] sample_out,
    output logic marker_output_enable
);

    initial begin
        if (SAMPLE_W < 2 || SAMPLE_W > 16) begin
            $error("itt_regs: SAMPLE_W must be 2 to 16");
        end
        if (LATENCY < 1 || LATENCY > 200) begin
            $error("itt_regs: LATENCY must be 1 to 200");
        end
    end

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    function automatic logic hit(
        input logic [itt_pkg::ADDR_W-1:0] addr,
        input logic [itt_pkg::ADDR_W-1:0] off
    );
        hit = (addr == off);
    endfunction

    wire sel_b0_dual = hit(reg_addr, itt_pkg::OFF_BANK0_DUAL);
    wire sel_b0_single = hit(reg_addr, itt_pkg::OFF_BANK0_SINGLE);
    wire sel_b1_dual = hit(reg_addr, itt_pkg::OFF_BANK1_DUAL);
    wire sel_b1_single = hit(reg_addr, itt_pkg::OFF_BANK1_SINGLE);
    wire sel_b4 = hit(reg_addr, itt_pkg::OFF_BANK4);
    wire sel_b5 = hit(reg_addr, itt_pkg::OFF_BANK5);
    wire sel_ctrl = hit(reg_addr, itt_pkg::OFF_MARKER_CTRL);

    wire wr_b0_dual = reg_wr & sel_b0_dual;
    wire wr_b0_single = reg_wr & sel_b0_single;
    wire wr_b1_dual = reg_wr & sel_b1_dual;
    wire wr_b1_single = reg_wr & sel_b1_single;
    wire wr_b4 = reg_wr & sel_b4;
    wire wr_b5 = reg_wr & sel_b5;
    wire wr_ctrl = reg_wr & sel_ctrl;

    // ------------------------------------------------------------
    // Trim storage
    // ------------------------------------------------------------
    logic [itt_pkg::TRIM_W-1:0] bank0_dual_mode_trim;
    logic [itt_pkg::TRIM_W-1:0] bank0_single_mode_trim;
    logic [itt_pkg::TRIM_W-1:0] bank1_dual_mode_trim;
    logic [itt_pkg::TRIM_W-1:0] bank1_single_mode_trim;
    logic [itt_pkg::TRIM_W-1:0] bank4_trim;
    logic [itt_pkg::TRIM_W-1:0] bank5_trim;
    logic [itt_pkg::DATA_W-1:0] sample_marker_control;

    // Sync reset lets the fuse pins be sampled as data, not as a reset value
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            bank0_dual_mode_trim <= fuse_bank0_dual;
            bank0_single_mode_trim <= fuse_bank0_single;
        end else begin
            if (wr_b0_dual) begin
                bank0_dual_mode_trim <= reg_wdata;
            end
            if (wr_b0_single) begin
                bank0_single_mode_trim <= reg_wdata;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            bank1_dual_mode_trim <= fuse_bank1_dual;
            bank1_single_mode_trim <= fuse_bank1_single;
        end else begin
            if (wr_b1_dual) begin
                bank1_dual_mode_trim <= reg_wdata;
            end
            if (wr_b1_single) begin
                bank1_single_mode_trim <= reg_wdata;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            bank4_trim <= fuse_bank4;
            bank5_trim <= fuse_bank5;
        end else begin
            if (wr_b4) begin
                bank4_trim <= reg_wdata;
            end
            if (wr_b5) begin
                bank5_trim <= reg_wdata;
            end
        end
    end

    // Whole byte stored; only bit 0 steers the datapath
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            sample_marker_control <= itt_pkg::MARKER_CTRL_RESET;
        end else if (wr_ctrl) begin
            sample_marker_control <= reg_wdata;
        end
    end

    // ------------------------------------------------------------
    // Trim selection by clock phase
    // ------------------------------------------------------------
    // Channel A banks switch phase with the mode; channel B stays at 0 deg
    logic [itt_pkg::TRIM_W-1:0] next_bank0_timing;
    logic [itt_pkg::TRIM_W-1:0] next_bank1_timing;
    logic [itt_pkg::TRIM_W-1:0] next_bank4_timing;
    logic [itt_pkg::TRIM_W-1:0] next_bank5_timing;

    assign next_bank0_timing = single_channel_mode
        ? bank0_single_mode_trim
        : bank0_dual_mode_trim;
    assign next_bank1_timing = single_channel_mode
        ? bank1_single_mode_trim
        : bank1_dual_mode_trim;
    assign next_bank4_timing = bank4_trim;
    assign next_bank5_timing = bank5_trim;

    // In reset, follow the fuses so the timing is valid on release
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            bank0_timing <= single_channel_mode ? fuse_bank0_single : fuse_bank0_dual;
            bank1_timing <= single_channel_mode ? fuse_bank1_single : fuse_bank1_dual;
            bank4_timing <= fuse_bank4;
            bank5_timing <= fuse_bank5;
        end else begin
            bank0_timing <= next_bank0_timing;
            bank1_timing <= next_bank1_timing;
            bank4_timing <= next_bank4_timing;
            bank5_timing <= next_bank5_timing;
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    // Data stand for exactly one cycle; unmapped offsets read zero
    logic [itt_pkg::DATA_W-1:0] read_mux;
    logic [itt_pkg::DATA_W-1:0] next_reg_rdata;

    assign read_mux =
        sel_b0_dual ? bank0_dual_mode_trim :
        sel_b0_single ? bank0_single_mode_trim :
        sel_b1_dual ? bank1_dual_mode_trim :
        sel_b1_single ? bank1_single_mode_trim :
        sel_b4 ? bank4_trim :
        sel_b5 ? bank5_trim :
        sel_ctrl ? sample_marker_control :
        itt_pkg::READ_IDLE;

    assign next_reg_rdata = reg_rd ? read_mux : itt_pkg::READ_IDLE;

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            reg_rdata <= itt_pkg::READ_IDLE;
        end else begin
            reg_rdata <= next_reg_rdata;
        end
    end

    // ------------------------------------------------------------
    // Sample marker datapath
    // ------------------------------------------------------------
    // Sync receiver enable lives elsewhere; software sets it too
    itt_pipe_if #(.SAMPLE_W(SAMPLE_W)) pif ();

    assign pif.sample_in = adc_sample;
    assign pif.marker_in = marker_in;
    assign pif.marker_en = sample_marker_control[itt_pkg::MARKER_EN_BIT];
    assign sample_out = pif.sample_out;
    assign marker_output_enable = sample_marker_control[itt_pkg::MARKER_EN_BIT];

    itt_marker_pipe #(
        .SAMPLE_W(SAMPLE_W),
        .LATENCY(LATENCY)
    ) u_pipe (
        .core_clk(core_clk),
        .resetn(resetn),
        .pif(pif.pipe)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking

    default disable iff (!resetn);

    sequence ctrl_write_s;
        reg_wr && sel_ctrl;
    endsequence

    sequence ctrl_read_s;
        reg_rd && sel_ctrl;
    endsequence

    bank0_dual_a: assert property (
        !$past(single_channel_mode) |->
        bank0_timing == $past(bank0_dual_mode_trim))
        else $error("bank 0 dual trim not applied");

    bank0_single_a: assert property (
        $past(single_channel_mode) |->
        bank0_timing == $past(bank0_single_mode_trim))
        else $error("bank 0 single trim not applied");

    bank1_phase_a: assert property (
        bank1_timing == ($past(single_channel_mode)
            ? $past(bank1_single_mode_trim)
            : $past(bank1_dual_mode_trim)))
        else $error("bank 1 trim does not follow the mode");

    bank4_both_a: assert property (
        $changed(single_channel_mode) ##1 1'b1 |->
        bank4_timing == $past(bank4_trim))
        else $error("bank 4 trim depends on mode");

    bank5_write_a: assert property (
        reg_wr && sel_b5 |-> ##2 bank5_timing == $past(reg_wdata, 2))
        else $error("bank 5 timing missed a write");

    fuse_load_a: assert property (
        @(posedge core_clk) !$past(resetn) |->
        bank4_trim == $past(fuse_bank4)
        && bank0_single_mode_trim == $past(fuse_bank0_single))
        else $error("trim not loaded from fuse at reset");

    trim_readback_a: assert property (
        reg_rd && sel_b1_dual |=> reg_rdata == $past(bank1_dual_mode_trim))
        else $error("trim read back wrong");

    marker_reset_a: assert property (
        @(posedge core_clk) !$past(resetn) |->
        !marker_output_enable && sample_marker_control == 8'h00)
        else $error("marker control not cleared by reset");

    marker_enable_a: assert property (
        ctrl_write_s |=> marker_output_enable == $past(reg_wdata[0]))
        else $error("marker enable did not follow write");

    reserved_rw_a: assert property (
        ctrl_write_s ##1 ctrl_read_s |=> reg_rdata == $past(reg_wdata, 2))
        else $error("reserved bits do not read back");

    read_single_a: assert property (
        !reg_rd |=> reg_rdata == 8'h00)
        else $error("read data stand beyond one cycle");

endmodule

// ===== testbench/test_itt_regs.sv
/*
 * Self-checking bench for the interleave trim and sample marker register bank.
 * Assumes the bank drives its ports as itt_regs declares, read data one cycle
 * after the strobe, and a sample path delay of LATENCY+1 clocks.
 */
`timescale 1ns/100ps

module test_itt_regs;
    localparam int LAT = 3;
    localparam int SW = 12;
    localparam int LIMIT = 4000;
    localparam logic [11:0] CTRL = itt_pkg::OFF_MARKER_CTRL;
    localparam logic [11:0] OFFS [6] = '{itt_pkg::OFF_BANK0_DUAL, itt_pkg::OFF_BANK0_SINGLE,
        itt_pkg::OFF_BANK1_DUAL, itt_pkg::OFF_BANK1_SINGLE, itt_pkg::OFF_BANK4,
        itt_pkg::OFF_BANK5};
    // Boundary values on purpose: all zeros and all ones among them
    localparam logic [7:0] NEWV [6] = '{8'h00, 8'hff, 8'h5a, 8'ha5, 8'h81, 8'h7e};

    logic core_clk;
    logic resetn;
    logic [itt_pkg::ADDR_W-1:0] reg_addr;
    logic [7:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] reg_rdata;
    logic single_channel_mode;
    logic [7:0] fuse [6];
    logic [7:0] tv [6];
    logic [7:0] bank0_timing;
    logic [7:0] bank1_timing;
    logic [7:0] bank4_timing;
    logic [7:0] bank5_timing;
    logic [SW-1:0] adc_sample;
    logic [SW-1:0] sample_out;
    logic marker_in;
    logic marker_output_enable;
    int cyc;
    int mismatches;
    int num_checks;

    itt_regs #(.SAMPLE_W(SW), .LATENCY(LAT)) i_dut (
        .core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .single_channel_mode(single_channel_mode),
        .fuse_bank0_dual(fuse[0]), .fuse_bank0_single(fuse[1]), .fuse_bank1_dual(fuse[2]),
        .fuse_bank1_single(fuse[3]), .fuse_bank4(fuse[4]), .fuse_bank5(fuse[5]),
        .bank0_timing(bank0_timing), .bank1_timing(bank1_timing),
        .bank4_timing(bank4_timing), .bank5_timing(bank5_timing),
        .adc_sample(adc_sample), .marker_in(marker_in), .sample_out(sample_out),
        .marker_output_enable(marker_output_enable));

    // ------------------------------------------------------------
    // Clock, sample stream and hang guard
    // ------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    // Stream is a pure function of the cycle number, so no history is kept
    function automatic logic [SW-1:0] pat(input int k);
        logic [31:0] v;
        v = (k * 32'h0000_00a7) ^ 32'h0000_05c3;
        return v[SW-1:0];
    endfunction

    function automatic logic mk(input int k);
        logic [31:0] v;
        v = k;
        return v[1] ^ v[3];
    endfunction

    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        adc_sample <= pat(cyc + 1);
        marker_in <= mk(cyc + 1);
        if (cyc == LIMIT) begin
            mismatches = mismatches + 1;
            report_and_stop();
        end
    end

    // ------------------------------------------------------------
    // Common tasks
    // ------------------------------------------------------------
    task automatic report_and_stop();
        if (mismatches == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks = num_checks + 1;
        if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Every call drives all bus signals once at one edge
    task automatic bus(input logic w, input logic r, input logic [11:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr <= w;
        reg_rd <= r;
        reg_addr <= a;
        reg_wdata <= d;
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        bus(1'b1, 1'b0, a, d);
        bus(1'b0, 1'b0, a, d);
    endtask

    task automatic rd_chk(input string what, input logic [11:0] a, input logic [7:0] exp);
        bus(1'b0, 1'b1, a, 8'h00);
        bus(1'b0, 1'b0, a, 8'h00);
        @(negedge core_clk);
        check(what, reg_rdata, exp);
    endtask

    task automatic check_banks();
        @(negedge core_clk);
        check("bank0_timing", bank0_timing, single_channel_mode ? tv[1] : tv[0]);
        check("bank1_timing", bank1_timing, single_channel_mode ? tv[3] : tv[2]);
        check("bank4_timing", bank4_timing, tv[4]);
        check("bank5_timing", bank5_timing, tv[5]);
    endtask

    task automatic stream(input logic en, input int n);
        logic [SW-1:0] exp;
        repeat (n) begin
            @(negedge core_clk);
            exp = pat(cyc - LAT - 1);
            if (en) begin
                exp[0] = mk(cyc - LAT - 1);
            end
            check("sample_out", sample_out, exp);
        end
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset(input logic [7:0] base);
        @(posedge core_clk);
        resetn <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            fuse[i] <= base + 8'(i * 37);
            tv[i] = base + 8'(i * 37);
        end
        repeat (16) @(posedge core_clk);
        resetn <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            rd_chk("trim after reset", OFFS[i], tv[i]);
        end
        rd_chk("control after reset", CTRL, 8'h00);
        check("enable after reset", marker_output_enable, 1'b0);
        check_banks();
    endtask

    task automatic t_trim_rw();
        for (int i = 0; i < 6; i++) begin
            tv[i] = NEWV[i];
            bus(1'b1, 1'b0, OFFS[i], tv[i]);
        end
        // Read in the cycle right after the write must see the new value
        tv[5] = 8'h3c;
        bus(1'b1, 1'b0, OFFS[5], tv[5]);
        bus(1'b0, 1'b1, OFFS[5], 8'h00);
        bus(1'b0, 1'b0, OFFS[5], 8'h00);
        @(negedge core_clk);
        check("read after write", reg_rdata, tv[5]);
        @(negedge core_clk);
        check("read data idle", reg_rdata, 8'h00);
        for (int i = 0; i < 6; i++) begin
            rd_chk("trim written", OFFS[i], tv[i]);
        end
        check_banks();
    endtask

    task automatic t_mode();
        @(posedge core_clk);
        single_channel_mode <= 1'b1;
        repeat (2) @(posedge core_clk);
        check_banks();
        tv[1] = 8'hc3;
        tv[3] = 8'h1e;
        wr(OFFS[1], tv[1]);
        wr(OFFS[3], tv[3]);
        repeat (2) @(posedge core_clk);
        check_banks();
        @(posedge core_clk);
        single_channel_mode <= 1'b0;
        repeat (2) @(posedge core_clk);
        check_banks();
    endtask

    task automatic t_unmapped();
        wr(12'h104, 8'ha5);
        wr(12'h161, 8'h5a);
        rd_chk("unmapped 104", 12'h104, 8'h00);
        rd_chk("unmapped 161", 12'h161, 8'h00);
        rd_chk("trim untouched", OFFS[1], tv[1]);
        rd_chk("control untouched", CTRL, 8'h00);
    endtask

    task automatic t_marker();
        // Read right behind the write: reserved bits must already read back
        bus(1'b1, 1'b0, CTRL, 8'hfe);
        rd_chk("reserved bits", CTRL, 8'hfe);
        check("enable off", marker_output_enable, 1'b0);
        stream(1'b0, 8);
        // Sync receiver enable lives outside this block
        wr(CTRL, 8'h01);
        rd_chk("enable bit", CTRL, 8'h01);
        check("enable on", marker_output_enable, 1'b1);
        repeat (LAT + 3) @(posedge core_clk);
        stream(1'b1, 12);
        wr(CTRL, 8'h00);
        repeat (LAT + 3) @(posedge core_clk);
        stream(1'b0, 8);
        // Left set so the next reset has something to clear
        wr(CTRL, 8'h81);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        resetn = 1'b0;
        reg_addr = 12'h000;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        single_channel_mode = 1'b0;
        adc_sample = pat(0);
        marker_in = mk(0);
        cyc = 0;
        mismatches = 0;
        num_checks = 0;
        for (int i = 0; i < 6; i++) begin
            fuse[i] = 8'h00;
        end
        t_reset(8'h21);
        t_trim_rw();
        t_mode();
        t_unmapped();
        t_marker();
        t_reset(8'hc4);
        report_and_stop();
    end
endmodule
